// ==== logic/i2c_mode_map.svh ====
// constants of the mode-control block: register offset, field positions,
// reset value and timing counts.
// assumes a 20 MHz system clock and the plain register port of the block.
`ifndef I2C_MODE_MAP_SVH
`define I2C_MODE_MAP_SVH

// ****************************************
// register map
// ****************************************
`define MODE_CTRL_OFS 8'h00
`define RSV7_BIT 7
`define WAIT_BIT 6
`define GUARD_BIT 3
`define COUNT_MSB 2
`define COUNT_LSB 0
`define MODE_RESET 8'h38
`define UNMAPPED_READ 8'h00

// ****************************************
// timing
// ****************************************
`define CLK_MHZ 20
// half period of the transfer clock that sets the scl bit time
`define XFER_HALF_NS 2500
`define XFER_HALF_CYC ((`XFER_HALF_NS * `CLK_MHZ + 999) / 1000)
// wait length in whole transfer clocks
`define WAIT_XFER_CLKS 2
`define WAIT_CYC (`WAIT_XFER_CLKS * 2 * `XFER_HALF_CYC)

`endif

// ==== logic/i2c_mode_pkg.sv ====
// types shared by the mode-control block.
// assumes the constants header is compiled alongside.
`default_nettype none

package i2c_mode_pkg;

  // one request on the register port
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // layout of the mode-control register as read back
  typedef struct packed {
    logic rsv7;
    logic wait_en;
    logic [1:0] ones;
    logic guard;
    logic [2:0] count;
  } mode_fields_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LOW = 3'b001,
    ST_HIGH = 3'b010,
    ST_WAIT = 3'b011,
    ST_SLAVE = 3'b100
  } frame_state_t;

endpackage

`default_nettype wire

// ==== logic/pin_sync.sv ====
// two flip-flop synchroniser for pins that arrive from outside sys_clk.
// assumes each bit is an independent level; no bus coherence is given.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // levels
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_sync_out
);

  logic [WIDTH-1:0] stage1_reg;

  // the first stage feeds only the second stage
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        stage1_reg[i] <= 1'b1;
        pin_sync_out[i] <= 1'b1;
      end else begin
        stage1_reg[i] <= pin_in[i];
        pin_sync_out[i] <= stage1_reg[i];
      end
    end
  end

endmodule

`default_nettype wire

// ==== logic/i2c_mode_wait_bitcount_ctrl.sv ====
// mode control of the i2c interface: wait insertion, guarded bit count
// and the scl timing of one transfer frame.
// assumes a neighbouring shift engine pulses xfer_start between frames and
// drives sda; the scl pin is open drain and resolved outside.
//
// Behaviour
// - as master with wait enabled, scl stays low two extra transfer clocks after the last data bit falls, before the ack bit.
// - with wait disabled, data bits and the ack bit follow one another with no extra low time.
// - in slave mode the wait bit is ignored and no wait is inserted.
// - reserved bits 5 and 4 always read as one.
// - a write with the guard bit at zero loads the three count bits from that write, unless a frame ends in the same cycle.
// - a write with the guard bit at one leaves the count bits unchanged.
// - the guard bit always reads as one and is not stored.
// - count code 000 means 9 bits and codes 001 to 111 mean 2 to 8 bits.
// - the count returns to 000 when a transfer with its ack bit completes.
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "i2c_mode_map.svh"

module i2c_mode_wait_bitcount_ctrl (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // register port
  input wire i2c_mode_pkg::reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  // neighbouring transfer logic
  input wire logic master_mode,
  input wire logic xfer_start,
  output logic xfer_busy,
  output logic xfer_done,
  output logic wait_active,
  output logic [3:0] bit_index,
  output logic [2:0] transfer_count,
  // bus pin
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n
);

  // ****************************************
  // constants and declarations
  // ****************************************
  localparam logic [7:0] HALF_M1 = 8'(`XFER_HALF_CYC - 1);
  localparam logic [7:0] WAIT_M1 = 8'(`WAIT_CYC - 1);

  logic rsv7_reg;
  logic wait_en_reg;
  logic [2:0] count_reg;
  logic [7:0] rdata_reg;
  logic wr_hit;
  logic rd_hit;
  logic scl_s;
  logic scl_prev_reg;
  logic scl_rise;
  i2c_mode_pkg::frame_state_t state_reg;
  i2c_mode_pkg::frame_state_t state_next;
  logic [7:0] tmr_reg;
  logic [7:0] tmr_next;
  logic [3:0] idx_reg;
  logic [3:0] idx_next;
  logic [3:0] frame_bits_reg;
  logic [3:0] frame_bits_next;
  logic done_next;
  logic done_reg;
  logic oe_n_reg;
  logic wait_act_reg;
  logic last_bit;
  logic last_data_bit;
  i2c_mode_pkg::mode_fields_t rd_view;

  function automatic logic [3:0] count_to_bits(input logic [2:0] code);
    count_to_bits = (code == 3'b000) ? 4'd9 : {1'b0, code} + 4'd1;
  endfunction

  // ****************************************
  // register port
  // ****************************************
  assign wr_hit = reg_req.wr && (reg_req.addr == `MODE_CTRL_OFS);
  assign rd_hit = reg_req.rd && (reg_req.addr == `MODE_CTRL_OFS);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rsv7_reg <= 1'(`MODE_RESET >> `RSV7_BIT);
      wait_en_reg <= 1'(`MODE_RESET >> `WAIT_BIT);
    end else if (wr_hit) begin
      rsv7_reg <= reg_req.wdata[`RSV7_BIT];
      wait_en_reg <= reg_req.wdata[`WAIT_BIT];
    end
  end

  // a frame end in the same cycle as a write wins: the write is taken to
  // belong to the frame just ended and would leave a stale count behind
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      count_reg <= 3'(`MODE_RESET);
    end else if (done_next) begin
      count_reg <= 3'h0;
    end else if (wr_hit && !reg_req.wdata[`GUARD_BIT]) begin
      count_reg <= reg_req.wdata[`COUNT_MSB:`COUNT_LSB];
    end
  end

  always_comb begin
    rd_view.rsv7 = rsv7_reg;
    rd_view.wait_en = wait_en_reg;
    rd_view.ones = 2'b11;
    rd_view.guard = 1'b1;
    rd_view.count = count_reg;
  end

  // read data stand for the single cycle after the strobe
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= 8'h00;
    end else if (rd_hit) begin
      rdata_reg <= rd_view;
    end else begin
      rdata_reg <= `UNMAPPED_READ;
    end
  end

  assign reg_rdata = rdata_reg;
  assign transfer_count = count_reg;

  // ****************************************
  // scl sampling
  // ****************************************
  pin_sync #(
    .WIDTH(1)
  ) u_scl_sync (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .pin_in(scl_in),
    .pin_sync_out(scl_s)
  );

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= scl_s;
    end
  end

  assign scl_rise = scl_s && !scl_prev_reg;

  // ****************************************
  // frame timing
  // ****************************************
  assign last_bit = (idx_reg == frame_bits_reg - 4'd1);
  assign last_data_bit = (idx_reg == frame_bits_reg - 4'd2);

  always_comb begin
    state_next = state_reg;
    tmr_next = tmr_reg;
    idx_next = idx_reg;
    frame_bits_next = frame_bits_reg;
    done_next = 1'b0;
    case (state_reg)
      i2c_mode_pkg::ST_IDLE: begin
        if (xfer_start) begin
          idx_next = 4'd0;
          frame_bits_next = count_to_bits(count_reg);
          tmr_next = HALF_M1;
          // slave frames follow the far clock and never wait
          state_next = master_mode ? i2c_mode_pkg::ST_LOW : i2c_mode_pkg::ST_SLAVE;
        end
      end
      i2c_mode_pkg::ST_LOW: begin
        tmr_next = tmr_reg - 8'd1;
        if (tmr_reg == 8'd0) begin
          tmr_next = HALF_M1;
          state_next = i2c_mode_pkg::ST_HIGH;
        end
      end
      i2c_mode_pkg::ST_HIGH: begin
        tmr_next = tmr_reg - 8'd1;
        if (tmr_reg == 8'd0) begin
          if (last_bit) begin
            done_next = 1'b1;
            state_next = i2c_mode_pkg::ST_IDLE;
          end else if (last_data_bit && wait_en_reg) begin
            idx_next = idx_reg + 4'd1;
            tmr_next = WAIT_M1;
            state_next = i2c_mode_pkg::ST_WAIT;
          end else begin
            idx_next = idx_reg + 4'd1;
            tmr_next = HALF_M1;
            state_next = i2c_mode_pkg::ST_LOW;
          end
        end
      end
      i2c_mode_pkg::ST_WAIT: begin
        tmr_next = tmr_reg - 8'd1;
        if (tmr_reg == 8'd0) begin
          tmr_next = HALF_M1;
          state_next = i2c_mode_pkg::ST_LOW;
        end
      end
      i2c_mode_pkg::ST_SLAVE: begin
        if (scl_rise) begin
          if (last_bit) begin
            done_next = 1'b1;
            state_next = i2c_mode_pkg::ST_IDLE;
          end else begin
            idx_next = idx_reg + 4'd1;
          end
        end
      end
      default: begin
        state_next = i2c_mode_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= i2c_mode_pkg::ST_IDLE;
      tmr_reg <= 8'h00;
      idx_reg <= 4'h0;
      frame_bits_reg <= 4'h9;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      tmr_reg <= tmr_next;
      idx_reg <= idx_next;
      frame_bits_reg <= frame_bits_next;
      done_reg <= done_next;
    end
  end

  // pin controls are registered from the next state so they change with it
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      oe_n_reg <= 1'b1;
      wait_act_reg <= 1'b0;
    end else begin
      oe_n_reg <= !(state_next == i2c_mode_pkg::ST_LOW || state_next == i2c_mode_pkg::ST_WAIT);
      wait_act_reg <= (state_next == i2c_mode_pkg::ST_WAIT);
    end
  end

  assign scl_out = 1'b0;
  assign scl_oe_n = oe_n_reg;
  assign wait_active = wait_act_reg;
  assign xfer_done = done_reg;
  assign xfer_busy = (state_reg != i2c_mode_pkg::ST_IDLE);
  assign bit_index = idx_reg;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_last_data_high_end;
    state_reg == i2c_mode_pkg::ST_HIGH && tmr_reg == 8'd0 && last_data_bit && !last_bit;
  endsequence

  sequence s_wait_held;
    (wait_active && !scl_oe_n)[*8];
  endsequence

  property p_wait_enter;
    s_last_data_high_end ##0 (wait_en_reg && state_reg != i2c_mode_pkg::ST_SLAVE)
      |=> state_reg == i2c_mode_pkg::ST_WAIT ##0 s_wait_held;
  endproperty
  a_wait_enter: assert property (p_wait_enter) else $error("wait not held after last data bit");

  property p_no_wait;
    s_last_data_high_end ##0 !wait_en_reg |=> state_reg == i2c_mode_pkg::ST_LOW && !wait_active;
  endproperty
  a_no_wait: assert property (p_no_wait) else $error("ack low phase delayed without wait");

  property p_slave_nowait;
    state_reg == i2c_mode_pkg::ST_SLAVE |-> !wait_active && scl_oe_n;
  endproperty
  a_slave_nowait: assert property (p_slave_nowait) else $error("slave frame drove scl");

  property p_rsv_ones;
    rd_hit |=> reg_rdata[5:4] == 2'b11;
  endproperty
  a_rsv_ones: assert property (p_rsv_ones) else $error("reserved bits did not read as one");

  property p_load;
    wr_hit && !reg_req.wdata[`GUARD_BIT] && !done_next
      |=> transfer_count == $past(reg_req.wdata[2:0]);
  endproperty
  a_load: assert property (p_load) else $error("count not loaded by unguarded write");

  property p_keep;
    wr_hit && reg_req.wdata[`GUARD_BIT] && !done_next |=> $stable(transfer_count);
  endproperty
  a_keep: assert property (p_keep) else $error("guarded write changed count");

  property p_guard_one;
    rd_hit |=> reg_rdata[`GUARD_BIT] && reg_rdata[2:0] == $past(count_reg);
  endproperty
  a_guard_one: assert property (p_guard_one) else $error("guard bit read back as zero");

  property p_len;
    state_reg == i2c_mode_pkg::ST_IDLE && xfer_start
      |=> frame_bits_reg == (($past(count_reg) == 3'b000) ? 4'd9 : {1'b0, $past(count_reg)} + 4'd1);
  endproperty
  a_len: assert property (p_len) else $error("frame length decoded wrongly");

  property p_clear;
    xfer_done |-> transfer_count == 3'b000 && !xfer_busy;
  endproperty
  a_clear: assert property (p_clear) else $error("count not cleared at frame end");

  property p_wait_resume;
    state_reg == i2c_mode_pkg::ST_WAIT && tmr_reg == 8'd0
      |=> state_reg == i2c_mode_pkg::ST_LOW && tmr_reg == HALF_M1 && !wait_active;
  endproperty
  a_wait_resume: assert property (p_wait_resume) else $error("clocking not resumed after wait");

endmodule

`default_nettype wire

// ==== tb/i2c_far_master.sv ====
// far-side bus master model: clocks scl for slave-mode frames.
// assumes an open-drain scl line with a pull-up resolved in the bench.
`timescale 1ns/1ps
`default_nettype none

module i2c_far_master (
  // bench clock, only used to time the scl edges
  input wire logic sys_clk,
  // open-drain scl pull, low = pulling
  output logic scl_drv_n
);
  // ****************************************
  // scl generation
  // ****************************************
  // scl stands released between frames; 8 clocks = 400 ns per bit clock,
  // edges placed right after a clock edge so the sync timing is repeatable
  initial begin
    scl_drv_n = 1'b1;
  end

  task automatic clock_bits(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      scl_drv_n <= 1'b0;
      repeat (4) @(posedge sys_clk);
      scl_drv_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
    end
  endtask
endmodule

`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench of the mode-control block: register port, master and slave frames.
// assumes the package, the map header and the far master model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "i2c_mode_map.svh"

module tb;
  logic sys_clk;
  logic arst_n;
  i2c_mode_pkg::reg_req_t reg_req;
  logic [7:0] reg_rdata;
  logic master_mode;
  logic xfer_start;
  logic xfer_busy;
  logic xfer_done;
  logic wait_active;
  logic [3:0] bit_index;
  logic [2:0] transfer_count;
  logic scl_out;
  logic scl_oe_n;
  logic scl_drv_n;
  logic scl_line;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  int w_m = 0;
  int cnt_m = 0;
  logic [7:0] got;

  // ****************************************
  // clock, wire, instances
  // ****************************************
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // pull-up: high unless a party pulls low
  assign scl_line = (scl_oe_n ? 1'b1 : scl_out) & scl_drv_n;

  i2c_mode_wait_bitcount_ctrl u_dut (
    .sys_clk(sys_clk), .arst_n(arst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .master_mode(master_mode), .xfer_start(xfer_start), .xfer_busy(xfer_busy),
    .xfer_done(xfer_done), .wait_active(wait_active), .bit_index(bit_index),
    .transfer_count(transfer_count), .scl_in(scl_line), .scl_out(scl_out),
    .scl_oe_n(scl_oe_n)
  );

  i2c_far_master u_far (.sys_clk(sys_clk), .scl_drv_n(scl_drv_n));

  // ****************************************
  // checking and closing
  // ****************************************
  task automatic chk_reg(input string nm, input logic [7:0] exp, input logic [7:0] seen);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic chk_cnt(input string nm, input int exp, input int seen);
    checks++;
    if (seen != exp) begin
      error_cnt++;
      $display("BAD %s expected %0d seen %0d", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // hang guard: whole run needs well under 15000 cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  // ****************************************
  // register port and model
  // ****************************************
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_req.addr <= a;
    reg_req.wdata <= d;
    reg_req.wr <= 1'b1;
    @(posedge sys_clk);
    reg_req.wr <= 1'b0;
    if (a == `MODE_CTRL_OFS) begin
      w_m = d[6];
      if (d[3] == 1'b0) cnt_m = d[2:0];
    end
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_req.addr <= a;
    reg_req.rd <= 1'b1;
    @(posedge sys_clk);
    reg_req.rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  function automatic logic [7:0] exp_mode();
    return {1'b0, w_m[0], 2'b11, 1'b1, cnt_m[2:0]};
  endfunction

  // ****************************************
  // frames
  // ****************************************
  task automatic run_frame(input logic m, input int code, input int w);
    int bits;
    int n;
    int lo;
    int wa;
    int en;
    int busy;
    bits = (code == 0) ? 9 : code + 1;
    // master: 100 cycles a bit plus the wait; slave: 8 cycles a far bit clock
    en = m ? bits * 100 + (w ? 200 : 0) + 1 : bits * 8 + 1;
    reg_wr(`MODE_CTRL_OFS, {1'b0, w[0], 2'b00, 1'b0, code[2:0]});
    reg_rd(`MODE_CTRL_OFS, got);
    chk_reg("mode before frame", exp_mode(), got);
    @(posedge sys_clk);
    master_mode <= m;
    xfer_start <= 1'b1;
    @(posedge sys_clk);
    xfer_start <= 1'b0;
    if (!m) fork u_far.clock_bits(bits); join_none
    n = 0;
    lo = 0;
    wa = 0;
    busy = 0;
    while (xfer_done !== 1'b1 && n < 3000) begin
      @(posedge sys_clk);
      n++;
      if (scl_oe_n === 1'b0 && scl_out === 1'b0) lo++;
      if (wait_active === 1'b1) wa++;
      if (xfer_busy === 1'b1) busy++;
    end
    chk_reg("count at done", 8'h00, {5'h00, transfer_count});
    chk_reg("last bit index", 8'(bits - 1), {4'h0, bit_index});
    chk_cnt("busy cycles", en - 1, busy);
    if (m) begin
      chk_cnt("frame cycles", bits * 100 + (w ? 200 : 0) + 1, n);
      chk_cnt("scl low cycles", bits * 50 + (w ? 200 : 0), lo);
      chk_cnt("wait cycles", w ? 200 : 0, wa);
    end else begin
      chk_cnt("slave done seen", 1, (n < 3000) ? 1 : 0);
      chk_cnt("slave frame cycles", en, n);
      chk_cnt("slave scl pulls", 0, lo);
      chk_cnt("slave wait cycles", 0, wa);
    end
    cnt_m = 0;
    reg_rd(`MODE_CTRL_OFS, got);
    chk_reg("mode after frame", exp_mode(), got);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [7:0] d;
    int r;
    arst_n = 1'b0;
    reg_req = '0;
    master_mode = 1'b1;
    xfer_start = 1'b0;
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'b1;
    void'($urandom(46));
    reg_rd(`MODE_CTRL_OFS, got);
    chk_reg("reset value", `MODE_RESET, got);
    reg_rd(8'h01 + 8'($urandom % 200), got);
    chk_reg("unmapped read", `UNMAPPED_READ, got);
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      d = 8'($urandom);
      d[7] = 1'b0;
      reg_wr((i % 4 == 3) ? 8'h05 : `MODE_CTRL_OFS, d);
      reg_rd(`MODE_CTRL_OFS, got);
      chk_reg("mode readback", exp_mode(), got);
      chk_reg("count port", {5'h00, cnt_m[2:0]}, {5'h00, transfer_count});
    end
    $display("test registers done");
    r = $urandom % 2;
    for (int c = 0; c < 8; c++) begin
      run_frame(1'b1, c, (c + r) % 2);
    end
    run_frame(1'b1, 0, 1);
    $display("test master frames done");
    for (int c = 0; c < 3; c++) begin
      run_frame(1'b0, int'($urandom % 8), 1);
    end
    $display("test slave frames done");
    reg_wr(`MODE_CTRL_OFS, 8'h45);
    @(posedge sys_clk);
    arst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    w_m = 0;
    cnt_m = 0;
    chk_reg("count after reset", 8'h00, {5'h00, transfer_count});
    reg_rd(`MODE_CTRL_OFS, got);
    chk_reg("reset value mid run", `MODE_RESET, got);
    run_frame(1'b1, 1, 1);
    $display("test mid-run reset done");
    report_and_stop();
  end
endmodule

`default_nettype wire
